// ### pmpg_defs.svh
// Register offsets, field positions and reset values of the pulse bank
`ifndef PMPG_DEFS_SVH
`define PMPG_DEFS_SVH
`define PMPG_NCH 16
`define PMPG_OFS_RUN 9'h000
`define PMPG_OFS_REALIGN 9'h004
`define PMPG_OFS_FLAGS 9'h008
`define PMPG_OFS_MASK 9'h00C
`define PMPG_OFS_SET 9'h010
`define PMPG_OFS_CLR 9'h014
`define PMPG_CH_FIRST 5'h02
`define PMPG_CH_LAST 5'h11
`define PMPG_SUB_CFG 2'h0
`define PMPG_SUB_PAT 2'h1
`define PMPG_SUB_REP 2'h2
`define PMPG_SUB_RLN 2'h3
`define PMPG_MODE_MSB 4
`define PMPG_MODE_LSB 0
`define PMPG_RATE_MSB 31
`define PMPG_RATE_LSB 8
`define PMPG_CNT_MSB 15
`define PMPG_CNT_LSB 0
`define PMPG_GAP_MSB 27
`define PMPG_GAP_LSB 16
`define PMPG_SRCA_MSB 4
`define PMPG_SRCA_LSB 0
`define PMPG_SRCA_ON 7
`define PMPG_SRCB_MSB 12
`define PMPG_SRCB_LSB 8
`define PMPG_SRCB_ON 15
`define PMPG_CFG_MASK 32'hFFFF_FF1F
`define PMPG_REP_MASK 32'h0FFF_FFFF
`define PMPG_RLN_MASK 32'h0000_9F9F
`define PMPG_MODE_SQUARE 5'h01
`define PMPG_MODE_FULL 5'h00
`define PMPG_LAST_FULL 5'h1F
`define PMPG_RST_WORD 32'h0000_0000
`define PMPG_RST_VEC 16'h0000
`endif

// ### pmpg_pkg.sv
// Types shared by the pulse bank design
package pmpg_pkg;
    typedef logic [31:0] pmpg_word_t;
    typedef logic [15:0] pmpg_chan_t;
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK = 2'b10
    } pmpg_bus_t;
    typedef enum logic [1:0] {
        PH_SHIFT = 2'b01,
        PH_GAP = 2'b10
    } pmpg_phase_t;
endpackage

// ### pmpg_top.sv
// Sixteen-channel pattern and square-wave pulse generator, Avalon-MM slave
`timescale 1ns/1ps
`include "pmpg_defs.svh"
module pmpg_top (
    input wire logic I_CLK_SYS,
    input wire logic I_SRST,
    input wire logic I_CE,
    input wire logic [8:0] I_AVS_ADDRESS,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [31:0] I_AVS_WRITEDATA,
    input wire logic [3:0] I_AVS_BYTEENABLE,
    output pmpg_pkg::pmpg_word_t O_AVS_READDATA,
    output logic O_AVS_WAITREQUEST,
    output pmpg_pkg::pmpg_chan_t O_PULSE,
    output logic O_IRQ
);
    import pmpg_pkg::*;

    // Byte enables expanded to a bit mask
    function automatic pmpg_word_t be_mask(input logic [3:0] be);
        pmpg_word_t m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        return m;
    endfunction

    // Merge written bytes into an old value
    function automatic pmpg_word_t merge(input pmpg_word_t old,
                                         input pmpg_word_t nw,
                                         input pmpg_word_t m);
        return (old & ~m) | (nw & m);
    endfunction

    // Channel block hit for a byte address
    function automatic logic ch_ok(input logic [8:0] a);
        return (a[8:4] >= `PMPG_CH_FIRST) && (a[8:4] <= `PMPG_CH_LAST);
    endfunction

    // Channel number of a channel block address
    function automatic logic [3:0] ch_of(input logic [8:0] a);
        logic [4:0] d;
        d = a[8:4] - `PMPG_CH_FIRST;
        return d[3:0];
    endfunction

    // Stop event of a selected source; out-of-range selectors never fire
    function automatic logic src_hit(input pmpg_chan_t ev,
                                     input logic [4:0] sel);
        return !sel[4] && ev[sel[3:0]];
    endfunction

    // Index of the last pattern bit for a mode value
    function automatic logic [4:0] last_of(input logic [4:0] mode);
        logic [4:0] r;
        if (mode == `PMPG_MODE_FULL) begin
            r = `PMPG_LAST_FULL;
        end else begin
            r = mode - 5'h01;
        end
        return r;
    endfunction

    pmpg_bus_t bus_q;
    pmpg_word_t rd_q;
    pmpg_word_t rd_d;
    pmpg_word_t wmask;
    pmpg_word_t wd;
    logic acc;
    logic wr_fire;
    logic rs_wr;
    pmpg_chan_t en_q;
    pmpg_chan_t en_d;
    pmpg_chan_t fl_q;
    pmpg_chan_t msk_q;
    pmpg_chan_t stop_ev;
    pmpg_chan_t dec;
    pmpg_chan_t trig;
    pmpg_chan_t rst_ch;
    pmpg_chan_t rs_halt;
    pmpg_chan_t out_q;
    logic irq_q;
    pmpg_word_t cfg_q [`PMPG_NCH];
    pmpg_word_t pat_q [`PMPG_NCH];
    pmpg_word_t rep_q [`PMPG_NCH];
    pmpg_word_t rln_q [`PMPG_NCH];

    // One wait state on every access so read data can come from a flop
    assign acc = I_AVS_READ | I_AVS_WRITE;
    assign O_AVS_WAITREQUEST = acc & ~((bus_q == BUS_ACK) & I_CE);
    assign wr_fire = I_AVS_WRITE & (bus_q == BUS_ACK) & I_CE;
    assign wmask = be_mask(I_AVS_BYTEENABLE);
    assign wd = I_AVS_WRITEDATA & wmask;

    // Bus handshake state
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SRST) begin
            bus_q <= BUS_IDLE;
        end else if (I_CE) begin
            case (bus_q)
                BUS_IDLE: begin
                    if (acc) begin
                        bus_q <= BUS_ACK;
                    end
                end
                BUS_ACK: begin
                    bus_q <= BUS_IDLE;
                end
                default: begin
                    bus_q <= BUS_IDLE;
                end
            endcase
        end
    end

    // Read mux; unmapped and write-only locations read as zero
    always_comb begin
        rd_d = `PMPG_RST_WORD;
        case (I_AVS_ADDRESS)
            `PMPG_OFS_RUN: rd_d = {16'h0000, en_q};
            `PMPG_OFS_FLAGS: rd_d = {16'h0000, fl_q};
            `PMPG_OFS_MASK: rd_d = {16'h0000, msk_q};
            default: begin
                if (ch_ok(I_AVS_ADDRESS) && I_AVS_ADDRESS[1:0] == 2'h0) begin
                    case (I_AVS_ADDRESS[3:2])
                        `PMPG_SUB_CFG: rd_d = cfg_q[ch_of(I_AVS_ADDRESS)];
                        `PMPG_SUB_PAT: rd_d = pat_q[ch_of(I_AVS_ADDRESS)];
                        `PMPG_SUB_REP: rd_d = rep_q[ch_of(I_AVS_ADDRESS)];
                        default: rd_d = rln_q[ch_of(I_AVS_ADDRESS)];
                    endcase
                end
            end
        endcase
    end

    // Read data captured in the wait cycle, held through the answer
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SRST) begin
            rd_q <= `PMPG_RST_WORD;
        end else if (I_CE && bus_q == BUS_IDLE && I_AVS_READ) begin
            rd_q <= rd_d;
        end
    end
    assign O_AVS_READDATA = rd_q;

    // Realign: any set bit fires; zero bits halt their channels
    assign rs_wr = wr_fire && I_AVS_ADDRESS == `PMPG_OFS_REALIGN && |wd;
    assign rs_halt = rs_wr ? ~wd[15:0] : `PMPG_RST_VEC;
    assign rst_ch = {`PMPG_NCH{rs_wr}} | trig;

    // Relaunch triggers from up to two selected stop sources
    always_comb begin
        for (int i = 0; i < `PMPG_NCH; i++) begin
            trig[i] = (rln_q[i][`PMPG_SRCA_ON] &
                       src_hit(stop_ev, rln_q[i][`PMPG_SRCA_MSB:`PMPG_SRCA_LSB]))
                    | (rln_q[i][`PMPG_SRCB_ON] &
                       src_hit(stop_ev, rln_q[i][`PMPG_SRCB_MSB:`PMPG_SRCB_LSB]));
        end
    end

    // Run bits: software, set/clear strobes, hardware halts, relaunch
    always_comb begin
        en_d = en_q;
        if (wr_fire && I_AVS_ADDRESS == `PMPG_OFS_RUN) begin
            en_d = 16'(merge({16'h0000, en_q}, I_AVS_WRITEDATA,
                             wmask));
        end
        if (wr_fire && I_AVS_ADDRESS == `PMPG_OFS_SET) begin
            en_d = en_d | wd[15:0];
        end
        if (wr_fire && I_AVS_ADDRESS == `PMPG_OFS_CLR) begin
            en_d = en_d & ~wd[15:0];
        end
        en_d = en_d & ~stop_ev & ~rs_halt;
        // Relaunch last so a self-triggered channel keeps running
        en_d = en_d | trig;
    end

    // Run register
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SRST) begin
            en_q <= `PMPG_RST_VEC;
        end else if (I_CE) begin
            en_q <= en_d;
        end
    end

    // Sticky stop flags; a new stop beats a same-cycle clear
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SRST) begin
            fl_q <= `PMPG_RST_VEC;
        end else if (I_CE) begin
            if (wr_fire && I_AVS_ADDRESS == `PMPG_OFS_FLAGS) begin
                fl_q <= (fl_q & ~wd[15:0]) | stop_ev;
            end else begin
                fl_q <= fl_q | stop_ev;
            end
        end
    end

    // Interrupt mask and gated request
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SRST) begin
            msk_q <= `PMPG_RST_VEC;
            irq_q <= 1'b0;
        end else if (I_CE) begin
            if (wr_fire && I_AVS_ADDRESS == `PMPG_OFS_MASK) begin
                msk_q <= 16'(merge({16'h0000, msk_q}, I_AVS_WRITEDATA,
                                   wmask));
            end
            irq_q <= |(fl_q & msk_q);
        end
    end
    assign O_IRQ = irq_q;

    // Channel configuration; count also counts down from the engine
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SRST) begin
            for (int i = 0; i < `PMPG_NCH; i++) begin
                cfg_q[i] <= `PMPG_RST_WORD;
                pat_q[i] <= `PMPG_RST_WORD;
                rep_q[i] <= `PMPG_RST_WORD;
                rln_q[i] <= `PMPG_RST_WORD;
            end
        end else if (I_CE) begin
            for (int i = 0; i < `PMPG_NCH; i++) begin
                if (dec[i]) begin
                    rep_q[i][`PMPG_CNT_MSB:`PMPG_CNT_LSB] <=
                        rep_q[i][`PMPG_CNT_MSB:`PMPG_CNT_LSB] - 16'h0001;
                end
                if (wr_fire && ch_ok(I_AVS_ADDRESS) &&
                    ch_of(I_AVS_ADDRESS) == 4'(i)) begin
                    case (I_AVS_ADDRESS[3:2])
                        `PMPG_SUB_CFG: cfg_q[i] <= merge(cfg_q[i],
                            I_AVS_WRITEDATA, wmask) & `PMPG_CFG_MASK;
                        `PMPG_SUB_PAT: pat_q[i] <= merge(pat_q[i],
                            I_AVS_WRITEDATA, wmask);
                        `PMPG_SUB_REP: rep_q[i] <= merge(rep_q[i],
                            I_AVS_WRITEDATA, wmask) & `PMPG_REP_MASK;
                        default: rln_q[i] <= merge(rln_q[i],
                            I_AVS_WRITEDATA, wmask) & `PMPG_RLN_MASK;
                    endcase
                end
            end
        end
    end

    // One engine per channel
    for (genvar g = 0; g < `PMPG_NCH; g++) begin : g_ch
        pmpg_phase_t ph_q;
        logic [23:0] div_q;
        logic [4:0] idx_q;
        logic [11:0] gap_q;
        logic [4:0] last;
        logic sq;
        logic [23:0] rate;
        logic [15:0] cnt;
        logic [11:0] gap;
        logic tick;
        logic tail;
        logic gap_end;
        logic go;

        assign sq = cfg_q[g][`PMPG_MODE_MSB:`PMPG_MODE_LSB]
                    == `PMPG_MODE_SQUARE;
        assign last = last_of(cfg_q[g][`PMPG_MODE_MSB:`PMPG_MODE_LSB]);
        assign rate = cfg_q[g][`PMPG_RATE_MSB:`PMPG_RATE_LSB];
        assign cnt = rep_q[g][`PMPG_CNT_MSB:`PMPG_CNT_LSB];
        assign gap = rep_q[g][`PMPG_GAP_MSB:`PMPG_GAP_LSB];
        assign tick = div_q == rate;
        assign tail = ph_q == PH_SHIFT && tick && !sq && idx_q == last;
        assign gap_end = ph_q == PH_GAP && gap_q <= 12'h001;
        // Realign takes priority; a trigger cannot gate its own source
        assign go = I_CE & en_q[g] & ~rs_wr;
        assign stop_ev[g] = go & tail & (cnt == 16'h0001);
        // Zero count never decrements: endless run
        assign dec[g] = go & ((tail & (cnt != 16'h0000) &
                        ((cnt == 16'h0001) | (gap == 12'h000))) | gap_end);

        // Shifter, divider and gap timer
        always_ff @(posedge I_CLK_SYS) begin
            if (I_SRST) begin
                ph_q <= PH_SHIFT;
                div_q <= 24'h000000;
                idx_q <= 5'h00;
                gap_q <= 12'h000;
                out_q[g] <= 1'b0;
            end else if (I_CE) begin
                if (rst_ch[g]) begin
                    ph_q <= PH_SHIFT;
                    div_q <= 24'h000000;
                    idx_q <= 5'h00;
                    out_q[g] <= sq ? 1'b0 : pat_q[g][0];
                end else if (en_q[g]) begin
                    case (ph_q)
                        PH_SHIFT: begin
                            if (!tick) begin
                                div_q <= div_q + 24'h000001;
                            end else begin
                                div_q <= 24'h000000;
                                if (sq) begin
                                    out_q[g] <= ~out_q[g];
                                end else if (idx_q != last) begin
                                    idx_q <= idx_q + 5'h01;
                                    out_q[g] <= pat_q[g][idx_q + 5'h01];
                                end else if (cnt > 16'h0001 &&
                                             gap != 12'h000) begin
                                    ph_q <= PH_GAP;
                                    gap_q <= gap;
                                end else begin
                                    idx_q <= 5'h00;
                                    // Halt keeps the last bit on the pin
                                    if (cnt != 16'h0001) begin
                                        out_q[g] <= pat_q[g][0];
                                    end
                                end
                            end
                        end
                        PH_GAP: begin
                            if (gap_end) begin
                                ph_q <= PH_SHIFT;
                                idx_q <= 5'h00;
                                out_q[g] <= pat_q[g][0];
                            end else begin
                                gap_q <= gap_q - 12'h001;
                            end
                        end
                        default: begin
                            ph_q <= PH_SHIFT;
                        end
                    endcase
                end
            end
        end
    end

    // Pins come straight from the engine flops
    assign O_PULSE = out_q;

endmodule

// ### pmpg_monitor.sv
// Port-level checker of the pulse bank, bound to the top module
`timescale 1ns/1ps
`include "pmpg_defs.svh"
module pmpg_monitor (
    input wire logic I_CLK_SYS,
    input wire logic I_SRST,
    input wire logic I_CE,
    input wire logic [8:0] I_AVS_ADDRESS,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [31:0] I_AVS_WRITEDATA,
    input wire logic [3:0] I_AVS_BYTEENABLE,
    input wire pmpg_pkg::pmpg_word_t O_AVS_READDATA,
    input wire logic O_AVS_WAITREQUEST,
    input wire pmpg_pkg::pmpg_chan_t O_PULSE,
    input wire logic O_IRQ
);
    import pmpg_pkg::*;
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (I_SRST);
    logic req;
    logic commit;
    // Full-word write accepted at this edge
    assign req = I_AVS_READ || I_AVS_WRITE;
    assign commit = I_AVS_WRITE && !O_AVS_WAITREQUEST && I_CE
        && I_AVS_BYTEENABLE == 4'hF;
    req_wait_a: assert property ($rose(req) |-> O_AVS_WAITREQUEST
        ##1 !O_AVS_WAITREQUEST) else $error("wait state count wrong");
    idle_nowait_a: assert property (!req |-> !O_AVS_WAITREQUEST)
        else $error("wait raised while idle");
    reset_quiet_a: assert property ($fell(I_SRST) |-> O_PULSE == '0
        && !O_IRQ) else $error("outputs not quiet after reset");
    wo_read_zero_a: assert property (I_AVS_READ && !O_AVS_WAITREQUEST
        && (I_AVS_ADDRESS == `PMPG_OFS_SET || I_AVS_ADDRESS == `PMPG_OFS_CLR
        || I_AVS_ADDRESS == `PMPG_OFS_REALIGN || I_AVS_ADDRESS >= 9'h120)
        |-> O_AVS_READDATA == '0) else $error("write-only read nonzero");
    mask_irq_a: assert property (commit && I_AVS_WRITEDATA[15:0] == '0
        && I_AVS_ADDRESS == `PMPG_OFS_MASK |-> ##2 !O_IRQ)
        else $error("irq stays with mask cleared");
    flag_irq_a: assert property (commit && I_AVS_WRITEDATA[15:0] == '1
        && I_AVS_ADDRESS == `PMPG_OFS_FLAGS |-> ##2 !O_IRQ)
        else $error("irq stays with flags cleared");
    halt_frozen_a: assert property (commit && I_AVS_WRITEDATA[15:0] == '1
        && I_AVS_ADDRESS == `PMPG_OFS_CLR |-> ##2 $stable(O_PULSE) [*4])
        else $error("pins move after halting all");
    rdata_hold_a: assert property (!I_AVS_READ |-> ##1
        $stable(O_AVS_READDATA)) else $error("read data moved unasked");
endmodule
bind pmpg_top pmpg_monitor u_mon (.I_CLK_SYS(I_CLK_SYS), .I_SRST(I_SRST),
    .I_CE(I_CE), .I_AVS_ADDRESS(I_AVS_ADDRESS), .I_AVS_READ(I_AVS_READ),
    .I_AVS_WRITE(I_AVS_WRITE), .I_AVS_WRITEDATA(I_AVS_WRITEDATA),
    .I_AVS_BYTEENABLE(I_AVS_BYTEENABLE), .O_AVS_READDATA(O_AVS_READDATA),
    .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST), .O_PULSE(O_PULSE),
    .O_IRQ(O_IRQ));

// ### pmpg_load.sv
// Load model that tallies high clocks seen on each pulse pin
`timescale 1ns/1ps
module pmpg_load (
    input wire logic i_clk,
    input wire logic i_clr,
    input wire pmpg_pkg::pmpg_chan_t i_pins,
    output logic [7:0] o_highs [16]
);
    import pmpg_pkg::*;
    // 8-bit tallies wrap, so measuring windows must stay short
    always_ff @(posedge i_clk) begin
        for (int i = 0; i < 16; i++) begin
            if (i_clr) begin
                o_highs[i] <= 8'h00;
            end else begin
                o_highs[i] <= o_highs[i] + {7'h00, i_pins[i]};
            end
        end
    end
endmodule

// ### pmpg_top_tb_top.sv
// Self-checking bench of the sixteen-channel pulse bank
`timescale 1ns/1ps
`define CMP(n, e, g) begin \
    n_compared++; \
    if ((g) !== (e)) begin \
        mismatches++; \
        $display("CHECK FAILED %s exp %h got %h", n, e, g); \
    end \
end
module pmpg_top_tb_top;
    import pmpg_pkg::*;
    typedef struct {
        logic [8:0] wa;
        logic [31:0] wv;
        logic [8:0] ra;
        logic [31:0] ex;
    } pmpg_row_t;
    logic clk = 1'b0, srst = 1'b1, rd = 1'b0, wr = 1'b0, clr = 1'b0;
    logic [8:0] adr = 9'h000;
    logic [31:0] wd = 32'h0000_0000;
    logic [31:0] q;
    pmpg_word_t rdat;
    pmpg_chan_t pins;
    logic wait_q, irq;
    logic [7:0] highs [16];
    logic [23:0] s;
    int mismatches = 0, n_compared = 0, cyc = 0, hit;
    // Write, then read back; write-only and unmapped places read zero
    pmpg_row_t rows [10] = '{
        '{9'h00C, 32'h0000_A5A5, 9'h00C, 32'h0000_A5A5},
        '{9'h010, 32'h0000_0006, 9'h000, 32'h0000_0006},
        '{9'h010, 32'h0000_0000, 9'h010, 32'h0000_0000},
        '{9'h014, 32'h0000_0002, 9'h000, 32'h0000_0004},
        '{9'h014, 32'h0000_0000, 9'h014, 32'h0000_0000},
        '{9'h000, 32'h0000_0000, 9'h000, 32'h0000_0000},
        '{9'h1FC, 32'hFFFF_FFFF, 9'h1FC, 32'h0000_0000},
        '{9'h02C, 32'hFFFF_FFFF, 9'h02C, 32'h0000_9F9F},
        '{9'h024, 32'hDEAD_BEEF, 9'h024, 32'hDEAD_BEEF},
        '{9'h02C, 32'h0000_0000, 9'h02C, 32'h0000_0000}
    };
    pmpg_top DUT (.I_CLK_SYS(clk), .I_SRST(srst), .I_CE(1'b1),
        .I_AVS_ADDRESS(adr), .I_AVS_READ(rd), .I_AVS_WRITE(wr),
        .I_AVS_WRITEDATA(wd), .I_AVS_BYTEENABLE(4'hF),
        .O_AVS_READDATA(rdat), .O_AVS_WAITREQUEST(wait_q),
        .O_PULSE(pins), .O_IRQ(irq));
    pmpg_load u_load (.i_clk(clk), .i_clr(clr), .i_pins(pins),
        .o_highs(highs));
    initial begin
        forever #25 clk = ~clk;
    end
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Hang guard, well above the few hundred cycles the run needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            conclude();
        end
    end
    // Request held until wait is sampled low at a rising edge
    task automatic bus(input logic w, input logic [8:0] a,
            input logic [31:0] d, output logic [31:0] r);
        @(posedge clk);
        wr <= w;
        rd <= !w;
        adr <= a;
        wd <= d;
        do begin
            @(posedge clk);
        end while (wait_q !== 1'b0);
        // Commit edge: data taken here, request dropped just after
        r = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic wrt(input logic [8:0] a, input logic [31:0] d);
        bus(1'b1, a, d, q);
    endtask
    task automatic chk(input string n, input logic [8:0] a,
            input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000, q);
        `CMP(n, e, q)
    endtask
    task automatic endt(input string n);
        $display("test %s done", n);
    endtask
    initial begin
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        foreach (rows[i]) begin
            wrt(rows[i].wa, rows[i].wv);
            chk("row", rows[i].ra, rows[i].ex);
        end
        endt("registers");
        // Channel 2: 4-bit pattern, two repeats, gap 2; 5 and 6 follow it
        wrt(9'h014, 32'h0000_FFFF);
        wrt(9'h040, 32'h0000_0004);
        wrt(9'h044, 32'h0000_000E);
        wrt(9'h048, 32'h0002_0002);
        wrt(9'h070, 32'h0000_0301);
        wrt(9'h074, 32'hFFFF_FFFF);
        wrt(9'h078, 32'h0000_0001);
        wrt(9'h07C, 32'h0000_0082);
        wrt(9'h08C, 32'h0000_8200);
        // Halted channels resume mid-pattern, so realign them first
        wrt(9'h004, 32'hFFFF_FFFF);
        wrt(9'h010, 32'h0000_0004);
        for (int i = 0; i < 24; i++) begin
            @(negedge clk);
            s[i] = pins[2];
        end
        hit = 0;
        for (int k = 0; k < 7; k++) begin
            if (s[k +: 18] === 18'h3FFBE) hit = 1;
        end
        `CMP("stream", 1, hit)
        chk("run", 9'h000, 32'h0000_0060);
        chk("flags", 9'h008, 32'h0000_0004);
        chk("count", 9'h048, 32'h0002_0000);
        `CMP("irq", 1'b1, irq)
        wrt(9'h008, 32'h0000_FFFF);
        chk("flags", 9'h008, 32'h0000_0000);
        endt("pattern");
        // Square wave, rate 3: eight clocks a period, half of them high
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        repeat (48) @(posedge clk);
        @(negedge clk);
        `CMP("highs", 8'h18, highs[5])
        wrt(9'h004, 32'hFFFF_FFFF);
        @(posedge clk);
        @(negedge clk);
        `CMP("realign", 1'b0, pins[5])
        wrt(9'h004, 32'hFFFF_FFDF);
        chk("run", 9'h000, 32'h0000_0040);
        endt("square");
        // Channel 2 relaunches itself after one pass
        wrt(9'h048, 32'h0000_0001);
        wrt(9'h04C, 32'h0000_0082);
        wrt(9'h010, 32'h0000_0004);
        repeat (30) @(posedge clk);
        chk("run", 9'h000, 32'h0000_0064);
        wrt(9'h004, 32'h0000_0000);
        chk("run", 9'h000, 32'h0000_0064);
        chk("flags", 9'h008, 32'h0000_0004);
        wrt(9'h00C, 32'h0000_0000);
        repeat (2) @(posedge clk);
        @(negedge clk);
        `CMP("irq", 1'b0, irq)
        wrt(9'h014, 32'h0000_FFFF);
        chk("run", 9'h000, 32'h0000_0000);
        endt("relaunch");
        // Second reset while channels run
        wrt(9'h010, 32'h0000_0064);
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(negedge clk);
        `CMP("pins", 16'h0000, pins)
        chk("run", 9'h000, 32'h0000_0000);
        endt("reset");
        conclude();
    end
endmodule
